/* File: common/lsop_consts.vh */
// lsop_consts.vh: offsets, field positions, reset values and counts
// for the link status, over-range and preset register bank.
`ifndef LSOP_CONSTS_VH
`define LSOP_CONSTS_VH

`define LSOP_ADDR_W          12
`define LSOP_OFF_STATUS      12'h205
`define LSOP_OFF_THR_I       12'h206
`define LSOP_OFF_THR_Q       12'h207
`define LSOP_OFF_PERIOD      12'h208
`define LSOP_OFF_MODE        12'h20C
`define LSOP_OFF_SEL         12'h20D

`define LSOP_ST_LINK_UP      6
`define LSOP_ST_SYNC         5
`define LSOP_ST_REALIGNED    4
`define LSOP_ST_MULTIFRAME_PHASE_SET_FLAG      3
`define LSOP_ST_PLL_LOCK     2

`define LSOP_RST_THR_I       8'hF2
`define LSOP_RST_THR_Q       8'hAB
`define LSOP_RST_PERIOD      3'h0
`define LSOP_RST_SEL         3'h0

// magnitude scale: 256 is full scale, so compare the top 8 magnitude bits
`define LSOP_SAMPLE_W        15
`define LSOP_MAG_SHIFT       6
// base monitoring period in clocks, scaled by 2**exponent
`define LSOP_BASE_PERIOD     8
`define LSOP_PERIOD_CNT_W    11

`define LSOP_NUM_PRESETS     8
`define LSOP_FREQ_W          32
`define LSOP_PHASE_W         16
`define LSOP_DELAY_W         8

`endif

/* File: dv/lsop_regs_sva.sv */
// lsop_regs_sva.sv: port-level checks of the status, over-range and preset bank.
// assumes binding into lsop_regs; sees its ports only.
`timescale 1ns/100ps
`include "lsop_consts.vh"
module lsop_regs_sva (
  input wire                    core_clk,
  input wire                    rstn,
  input wire                    reg_wr,
  input wire                    reg_rd,
  input wire [`LSOP_ADDR_W-1:0] reg_addr,
  input wire [7:0]              reg_wdata,
  input wire [7:0]              reg_rdata,
  input wire                    link_enable_bit,
  input wire                    data_encoding_state,
  input wire                    serdes_pll_locked,
  input wire                    sync_diff_select,
  input wire                    single_ended_sync_pin,
  input wire                    sysref_realign,
  input wire [1:0]              level_exceed_bits,
  input wire                    link_block_rstn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire st_rd = reg_rd && reg_addr == `LSOP_OFF_STATUS;
  sequence s_se_quiet;
    (!sync_diff_select && $stable(single_ended_sync_pin))[*4];
  endsequence
  sequence s_clr4;
    reg_wr && reg_addr == `LSOP_OFF_STATUS && reg_wdata[4] && !sysref_realign;
  endsequence
  property p_link_hold; !link_enable_bit |=> !link_block_rstn; endproperty
  property p_exc_clr; !link_enable_bit |=> level_exceed_bits == 2'h0; endproperty
  property p_exc_hold;
    $changed(level_exceed_bits) && link_enable_bit
      |=> ($stable(level_exceed_bits) || !link_enable_bit)[*7];
  endproperty
  property p_bit6; st_rd |=> reg_rdata[6] == $past(link_enable_bit && data_encoding_state);
  endproperty
  property p_bit2; st_rd |=> reg_rdata[2] == $past(link_enable_bit && serdes_pll_locked);
  endproperty
  property p_bit5; s_se_quiet ##0 st_rd |=> reg_rdata[5] == $past(single_ended_sync_pin);
  endproperty
  property p_w1c; s_clr4 ##1 !sysref_realign ##1 (st_rd && !sysref_realign) |=> !reg_rdata[4];
  endproperty
  property p_unmap;
    reg_rd && !(reg_addr inside {[12'h205:12'h208], 12'h20C, 12'h20D}) |=> reg_rdata == 8'h00;
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link block not held");
  a_exc_clr: assert property (p_exc_clr) else $error("exceed bits not cleared");
  a_exc_hold: assert property (p_exc_hold) else $error("exceed bits too short");
  a_bit6: assert property (p_bit6) else $error("link up bit wrong");
  a_bit2: assert property (p_bit2) else $error("pll lock bit wrong");
  a_bit5: assert property (p_bit5) else $error("sync bit wrong");
  a_w1c: assert property (p_w1c) else $error("realign flag not cleared");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // lsop_regs_sva
bind lsop_regs lsop_regs_sva lsop_regs_sva_inst (.*);

/* File: dv/lsop_rx_model.sv */
// lsop_rx_model.sv: far link receiver model, drives sync pins and sysref.
// assumes the bench steers it just after core_clk edges.
`timescale 1ns/100ps
module lsop_rx_model (
  input  wire core_clk,
  input  wire want_sync,
  input  wire ref_go,
  input  wire ref_moved,
  output reg  se_req_n,
  output reg  diff_req_n,
  output reg  ref_pulse,
  output reg  ref_shift
);
  initial {se_req_n, diff_req_n, ref_pulse, ref_shift} = 4'hC;
  // diff pin opposite so the selected pin shows
  always @(posedge core_clk) begin
    se_req_n   <= #1 ~want_sync;
    diff_req_n <= #1 want_sync;
    ref_pulse  <= #1 ref_go;
    ref_shift  <= #1 ref_moved;
  end
endmodule // lsop_rx_model

/* File: dv/testbench.sv */
// testbench.sv: random and corner stimulus for lsop_regs, self-checking.
// assumes lsop_rx_model stands for the far link end.
`timescale 1ns/100ps
`include "lsop_consts.vh"
module testbench;
  reg core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, want_sync = 0, ref_go = 0;
  reg link_enable_bit = 0, data_encoding_state = 0, sync_diff_select = 0, ref_moved = 0;
  reg serdes_pll_locked = 0, sample_valid = 0, preset_wr = 0;
  reg [11:0] reg_addr = 0;
  reg [7:0] reg_wdata = 0, preset_wr_delay = 0, d, ti, tq;
  reg [14:0] sample_i = 0, sample_q = 0;
  reg [2:0] preset_index_pins = 0, preset_wr_index = 0;
  reg [31:0] preset_wr_freq = 0;
  reg [15:0] preset_wr_phase = 0;
  wire single_ended_sync_pin, differential_sync_pin, sysref_event, sysref_realign;
  wire link_block_rstn;
  wire [7:0] reg_rdata, preset_delay_setting;
  wire [1:0] level_exceed_bits;
  wire [2:0] active_preset;
  wire [31:0] preset_tuning_word;
  wire [15:0] preset_phase_word;
  reg [55:0] store [0:7];
  int fail_count = 0, samples_checked = 0, n, e, k, ci, cq;
  lsop_regs lsop_regs_inst (.*);
  lsop_rx_model lsop_rx_model_inst (.core_clk(core_clk), .want_sync(want_sync),
    .ref_go(ref_go), .ref_moved(ref_moved), .se_req_n(single_ended_sync_pin),
    .diff_req_n(differential_sync_pin), .ref_pulse(sysref_event), .ref_shift(sysref_realign));
  always #10 core_clk = ~core_clk;
  task chk(input ok);
    samples_checked++;
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: value differs", $time);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task wr(input [11:0] a, input [7:0] v);
    reg_wr = 1; reg_addr = a; reg_wdata = v; tick(1); reg_wr = 0; tick(1);
  endtask
  task rd(input [11:0] a, input [7:0] m, input [7:0] x);
    reg_rd = 1; reg_addr = a; tick(1); reg_rd = 0; chk((reg_rdata & m) === x); tick(1);
  endtask
  task chkp(input [2:0] x);
    chk(active_preset === x && {preset_tuning_word, preset_phase_word,
      preset_delay_setting} === store[x]);
  endtask
  function [7:0] mag(input [14:0] s);
    reg [14:0] a;
    a = s[14] ? 15'h0 - s : s;
    mag = a[14] ? 8'hFF : a[13:6];
  endfunction
  function [14:0] smp(input [7:0] g);
    smp = {1'b0, g, 6'($urandom)};
    if ($urandom_range(1)) smp = 15'h0 - smp;
  endfunction
  task wrap_up;
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up;
  end
  initial begin
    d = 8'($urandom(32'h06AC));
    tick(20);
    rstn = 1;
    chk(link_block_rstn === 1'b0 && level_exceed_bits === 2'h0);
    rd(`LSOP_OFF_STATUS, 8'hCF, 8'h00);
    rd(`LSOP_OFF_THR_I, 8'hFF, 8'hF2);
    rd(`LSOP_OFF_THR_Q, 8'hFF, 8'hAB);
    rd(`LSOP_OFF_PERIOD, 8'hFF, 8'h00);
    rd(`LSOP_OFF_MODE, 8'hFF, 8'h00);
    rd(`LSOP_OFF_SEL, 8'hFF, 8'h00);
    for (n = 0; n < 20; n++) begin
      k = $urandom_range(4);
      d = 8'($urandom);
      wr(k < 3 ? 12'h206 + k : 12'h209 + k, d);
      rd(k < 3 ? 12'h206 + k : 12'h209 + k, 8'hFF, d & (k < 2 ? 8'hFF : k == 3 ? 8'h01 : 8'h07));
    end
    wr(12'h20A, d);
    rd(12'h20A, 8'hFF, 8'h00);
    link_enable_bit = 1; data_encoding_state = 1; serdes_pll_locked = 1; want_sync = 1;
    tick(6);
    chk(link_block_rstn === 1'b1);
    rd(`LSOP_OFF_STATUS, 8'h64, 8'h44);
    sync_diff_select = 1; tick(6);
    rd(`LSOP_OFF_STATUS, 8'h20, 8'h20);
    sync_diff_select = 0; want_sync = 0; data_encoding_state = 0; serdes_pll_locked = 0; tick(6);
    rd(`LSOP_OFF_STATUS, 8'h64, 8'h20);
    for (n = 0; n < 2; n++) begin
      ref_go = 1; tick(1); ref_go = 0; tick(3);
      rd(`LSOP_OFF_STATUS, 8'h18, n ? 8'h00 : 8'h08);
      wr(`LSOP_OFF_STATUS, 8'h08);
    end
    ref_moved = 1; tick(1); ref_moved = 0; tick(3);
    rd(`LSOP_OFF_STATUS, 8'h18, 8'h10);
    wr(`LSOP_OFF_STATUS, 8'h10);
    rd(`LSOP_OFF_STATUS, 8'h10, 8'h00);
    preset_wr = 1;
    for (k = 0; k < 8; k++) begin
      store[k] = {$urandom, 24'($urandom)};
      preset_wr_index = 3'(k);
      {preset_wr_freq, preset_wr_phase, preset_wr_delay} = store[k];
      tick(1);
    end
    preset_wr = 0;
    wr(`LSOP_OFF_MODE, 8'h01);
    for (k = 7; k >= 0; k--) begin
      preset_index_pins = 3'($urandom);
      wr(`LSOP_OFF_SEL, 8'(k)); tick(4);
      chkp(3'(k));
    end
    wr(`LSOP_OFF_MODE, 8'h00);
    for (n = 0; n < 8; n++) begin
      preset_index_pins = 3'($urandom); tick(6);
      chkp(preset_index_pins);
    end
    for (e = 0; e < 4; e++) begin
      link_enable_bit = 0; tick(2);
      chk(level_exceed_bits === 2'h0);
      ti = 8'($urandom_range(255, 1)); tq = 8'($urandom_range(255, 1));
      wr(`LSOP_OFF_THR_I, ti); wr(`LSOP_OFF_THR_Q, tq); wr(`LSOP_OFF_PERIOD, 8'(e));
      link_enable_bit = 1; ci = 0; cq = 0;
      tick($urandom_range(8 << e));
      sample_i = smp(e[0] ? ti : ti - 8'h01); sample_q = smp(e[0] ? tq - 8'h01 : tq);
      sample_valid = 1; d = mag(sample_i) >= ti; tick(1); sample_valid = 0;
      ci = level_exceed_bits[0]; cq = level_exceed_bits[1];
      for (n = 0; n < 3 * (8 << e); n++) begin
        sample_i = 15'($urandom); sample_q = 15'($urandom); tick(1);
        ci += level_exceed_bits[0]; cq += level_exceed_bits[1];
      end
      chk(ci == (d[0] ? 8 << e : 0) && cq == (d[0] ? 0 : 8 << e));
    end
    wrap_up;
  end
endmodule // testbench

/* File: hdl/lsop_regs.v */
// lsop_regs.v: link status, over-range detection and preset selection.
// assumes a simple synchronous register port on core_clk and pins
// (sync, preset index) arriving asynchronously.
//
// Functional notes
// - status bit 6 shows link in data encoding
// - status bit 5 follows selected sync pin, two core_clk cycles late
// - bit 4 sets on sysref realign, write-1 clears
// - bit 3 sets on first sysref, write-1 clears
// - status bit 2 shows serializer pll lock
// - i level exceed bit set at threshold
// - q level exceed bit set at threshold
// - threshold compared on 256 full scale
// - period doubles per exponent field increment
// - period change while enabled may shift phase
// - eight presets, only the active one applied
// - mode bit picks pins or register index
// - preset index register bits 2-0, rest zero
// - link enable low holds link block reset
`timescale 1ns/100ps
`include "lsop_consts.vh"

module lsop_regs (
  input  wire                          core_clk,
  input  wire                          rstn,
  input  wire                          reg_wr,
  input  wire                          reg_rd,
  input  wire [`LSOP_ADDR_W-1:0]       reg_addr,
  input  wire [7:0]                    reg_wdata,
  output reg  [7:0]                    reg_rdata,
  input  wire                          link_enable_bit,
  input  wire                          data_encoding_state,
  input  wire                          sync_diff_select,
  input  wire                          single_ended_sync_pin,
  input  wire                          differential_sync_pin,
  input  wire                          sysref_event,
  input  wire                          sysref_realign,
  input  wire                          serdes_pll_locked,
  input  wire                          sample_valid,
  input  wire [`LSOP_SAMPLE_W-1:0]     sample_i,
  input  wire [`LSOP_SAMPLE_W-1:0]     sample_q,
  input  wire [2:0]                    preset_index_pins,
  input  wire                          preset_wr,
  input  wire [2:0]                    preset_wr_index,
  input  wire [`LSOP_FREQ_W-1:0]       preset_wr_freq,
  input  wire [`LSOP_PHASE_W-1:0]      preset_wr_phase,
  input  wire [`LSOP_DELAY_W-1:0]      preset_wr_delay,
  output reg  [1:0]                    level_exceed_bits,
  output reg                           link_block_rstn,
  output reg  [2:0]                    active_preset,
  output reg  [`LSOP_FREQ_W-1:0]       preset_tuning_word,
  output reg  [`LSOP_PHASE_W-1:0]      preset_phase_word,
  output reg  [`LSOP_DELAY_W-1:0]      preset_delay_setting
);

  // registers
  reg [7:0]  i_level_threshold_r;
  reg [7:0]  q_level_threshold_r;
  reg [2:0]  monitor_period_exponent_r;
  reg        preset_mode_r;
  reg [2:0]  preset_index_field_r;
  reg        realigned_r;
  reg        multiframe_phase_set_flag_r;
  reg        first_sysref_seen_r;

  // synchronisers for pin inputs
  reg        sync_se_s1_r;
  reg        sync_se_s2_r;
  reg        sync_df_s1_r;
  reg        sync_df_s2_r;
  reg [2:0]  pins_s1_r;
  reg [2:0]  pins_s2_r;

  // over-range monitor
  reg [`LSOP_PERIOD_CNT_W-1:0] period_cnt_r;
  reg [1:0]                    exceed_acc_r;

  // preset storage
  reg [`LSOP_FREQ_W-1:0]  freq_mem  [0:`LSOP_NUM_PRESETS-1];
  reg [`LSOP_PHASE_W-1:0] phase_mem [0:`LSOP_NUM_PRESETS-1];
  reg [`LSOP_DELAY_W-1:0] delay_mem [0:`LSOP_NUM_PRESETS-1];

  wire wr_status = reg_wr && (reg_addr == `LSOP_OFF_STATUS);
  wire clr_realign = wr_status && reg_wdata[`LSOP_ST_REALIGNED];
  wire clr_multiframe_phase_set_flag = wr_status && reg_wdata[`LSOP_ST_MULTIFRAME_PHASE_SET_FLAG];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_se_s1_r <= 1'b1;
      sync_se_s2_r <= 1'b1;
      sync_df_s1_r <= 1'b1;
      sync_df_s2_r <= 1'b1;
      pins_s1_r    <= 3'h0;
      pins_s2_r    <= 3'h0;
    end else begin
      sync_se_s1_r <= single_ended_sync_pin;
      sync_se_s2_r <= sync_se_s1_r;
      sync_df_s1_r <= differential_sync_pin;
      sync_df_s2_r <= sync_df_s1_r;
      pins_s1_r    <= preset_index_pins;
      pins_s2_r    <= pins_s1_r;
    end
  end

  // register writes
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      i_level_threshold_r       <= `LSOP_RST_THR_I;
      q_level_threshold_r       <= `LSOP_RST_THR_Q;
      monitor_period_exponent_r <= `LSOP_RST_PERIOD;
      preset_mode_r             <= 1'b0;
      preset_index_field_r      <= `LSOP_RST_SEL;
    end else if (reg_wr) begin
      case (reg_addr)
        `LSOP_OFF_THR_I:  i_level_threshold_r <= reg_wdata;
        `LSOP_OFF_THR_Q:  q_level_threshold_r <= reg_wdata;
        `LSOP_OFF_PERIOD: monitor_period_exponent_r <= reg_wdata[2:0];
        `LSOP_OFF_MODE:   preset_mode_r <= reg_wdata[0];
        `LSOP_OFF_SEL:    preset_index_field_r <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // sticky alignment flags; a set in the clear cycle wins
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      realigned_r                 <= 1'b0;
      multiframe_phase_set_flag_r <= 1'b0;
      first_sysref_seen_r         <= 1'b0;
    end else begin
      if (link_enable_bit && sysref_realign)
        realigned_r <= 1'b1;
      else if (clr_realign)
        realigned_r <= 1'b0;
      if (!link_enable_bit)
        first_sysref_seen_r <= 1'b0;
      else if (sysref_event)
        first_sysref_seen_r <= 1'b1;
      if (link_enable_bit && sysref_event && !first_sysref_seen_r)
        multiframe_phase_set_flag_r <= 1'b1;
      else if (clr_multiframe_phase_set_flag)
        multiframe_phase_set_flag_r <= 1'b0;
    end
  end

  // register read mux, registered
  wire sync_sel = sync_diff_select ? sync_df_s2_r : sync_se_s2_r;
  reg [7:0] rdata_nxt;
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `LSOP_OFF_STATUS: begin
        rdata_nxt[`LSOP_ST_LINK_UP]   = link_enable_bit & data_encoding_state;
        rdata_nxt[`LSOP_ST_SYNC]      = sync_sel;
        rdata_nxt[`LSOP_ST_REALIGNED] = realigned_r;
        rdata_nxt[`LSOP_ST_MULTIFRAME_PHASE_SET_FLAG]   = multiframe_phase_set_flag_r;
        rdata_nxt[`LSOP_ST_PLL_LOCK]  = link_enable_bit & serdes_pll_locked;
      end
      `LSOP_OFF_THR_I:  rdata_nxt = i_level_threshold_r;
      `LSOP_OFF_THR_Q:  rdata_nxt = q_level_threshold_r;
      `LSOP_OFF_PERIOD: rdata_nxt = {5'h00, monitor_period_exponent_r};
      `LSOP_OFF_MODE:   rdata_nxt = {7'h00, preset_mode_r};
      `LSOP_OFF_SEL:    rdata_nxt = {5'h00, preset_index_field_r};
      default:          rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // magnitude, top 8 bits on a 256 = full-scale scale
  function [7:0] mag8;
    input [`LSOP_SAMPLE_W-1:0] s;
    reg   [`LSOP_SAMPLE_W-1:0] a;
    begin
      a = s[`LSOP_SAMPLE_W-1] ? (~s + 1'b1) : s;
      if (a[`LSOP_SAMPLE_W-1])
        mag8 = 8'hFF;
      else
        mag8 = a[`LSOP_SAMPLE_W-2:`LSOP_MAG_SHIFT];
    end
  endfunction

  wire hit_i = sample_valid && (mag8(sample_i) >= i_level_threshold_r);
  wire hit_q = sample_valid && (mag8(sample_q) >= q_level_threshold_r);

  // period length = base * 2**exponent; a mid-period change only moves the end
  wire [`LSOP_PERIOD_CNT_W-1:0] base_len  = `LSOP_BASE_PERIOD;
  wire [`LSOP_PERIOD_CNT_W-1:0] period_len = base_len << monitor_period_exponent_r;
  wire period_end = (period_cnt_r >= period_len - 1'b1);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      period_cnt_r      <= {`LSOP_PERIOD_CNT_W{1'b0}};
      exceed_acc_r      <= 2'b00;
      level_exceed_bits <= 2'b00;
    end else if (!link_enable_bit) begin
      period_cnt_r      <= {`LSOP_PERIOD_CNT_W{1'b0}};
      exceed_acc_r      <= 2'b00;
      level_exceed_bits <= 2'b00;
    end else if (period_end) begin
      period_cnt_r      <= {`LSOP_PERIOD_CNT_W{1'b0}};
      level_exceed_bits <= exceed_acc_r | {hit_q, hit_i};
      exceed_acc_r      <= 2'b00;
    end else begin
      period_cnt_r <= period_cnt_r + 1'b1;
      exceed_acc_r <= exceed_acc_r | {hit_q, hit_i};
    end
  end

  // preset storage and active selection
  wire [2:0] sel_nxt = preset_mode_r ? preset_index_field_r : pins_s2_r;

  always @(posedge core_clk) begin
    if (preset_wr) begin
      freq_mem[preset_wr_index]  <= preset_wr_freq;
      phase_mem[preset_wr_index] <= preset_wr_phase;
      delay_mem[preset_wr_index] <= preset_wr_delay;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_preset        <= 3'h0;
      preset_tuning_word   <= {`LSOP_FREQ_W{1'b0}};
      preset_phase_word    <= {`LSOP_PHASE_W{1'b0}};
      preset_delay_setting <= {`LSOP_DELAY_W{1'b0}};
      link_block_rstn      <= 1'b0;
    end else begin
      active_preset        <= sel_nxt;
      preset_tuning_word   <= freq_mem[sel_nxt];
      preset_phase_word    <= phase_mem[sel_nxt];
      preset_delay_setting <= delay_mem[sel_nxt];
      link_block_rstn      <= link_enable_bit;
    end
  end

endmodule // lsop_regs
